// ### core/pdt_params.svh
/*
 Constants for the palette converter test and control logic: register
 locations, field positions, reset values and channel codes.
 Assumes inclusion by the package and the design module only.
*/
// Summary of operation
// - Write to test register stores control word; read returns selected channel data.
// - Control word is the three low data bits, selecting eight channels.
// - Codes: 0-2 palette RGB, 3 ident, 4-6 ones RGB, 7 analog test.
// - Palette channel read returns colour byte at pixel-addressed palette location.
// - Each palette read advances red to green to blue, then back to red.
// - Ident read advances into palette channels; ident returns only on rewrite.
// - Ident value is a fixed constant readable regardless of pixel activity.
// - Ones channel adds set-bit count of whole selected byte per accessed word.
// - Temporary ones accumulator saturates at 255; overflow holds it at 255.
// - Ones accumulation samples palette output on every other pixel.
// - Vertical sync falling edge copies accumulator to result, then clears it.
// - Vertical sync falling edge without a test register access advances ones selector red to green to blue, then back to red.
// - Odd/even sample phase persists across frames until reset.
// - Analog channel: bits 7-4 read/write selects, bit 3 read-only result.
// - Selects 1010 R-B, 1001 R-ref, 0110 G-B, 0101 G-ref; one means greater.
// - Comparator result captured on falling edge of blank-derived strobe.
// - Control bit 4 selects pedestal: zero none, one 7.5 IRE.
// - Control bit 5 enables sync on green analog output.
// - Control bit 6 selects pixel bus byte order: zero little, one big.
// - Control bit 7 drives external select output only.
`ifndef PDT_PARAMS_SVH
`define PDT_PARAMS_SVH
`define PDT_ADDR_GENERAL 1'h0
`define PDT_ADDR_TEST 1'h1
`define PDT_GEN_RESET 8'h03
`define PDT_TEST_RESET 8'h00
`define PDT_BIT_PEDESTAL 4
`define PDT_BIT_SYNC_GREEN 5
`define PDT_BIT_BIG_ENDIAN 6
`define PDT_BIT_EXT_SEL 7
`define PDT_BIT_RESULT 3
`define PDT_CH_RED 3'h0
`define PDT_CH_GREEN 3'h1
`define PDT_CH_BLUE 3'h2
`define PDT_CH_IDENT 3'h3
`define PDT_CH_ONES_RED 3'h4
`define PDT_CH_ONES_GREEN 3'h5
`define PDT_CH_ONES_BLUE 3'h6
`define PDT_CH_ANALOG 3'h7
`define PDT_ACC_MAX 8'hFF
`endif

// ### core/pdt_pkg.sv
/*
 Types for the palette converter test and control logic.
 Assumes pdt_params.svh is on the include path.
*/
`include "pdt_params.svh"
package pdt_pkg;
  typedef struct packed {
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
  } pdt_rgb_t;
  typedef struct packed {
    logic ext_sel;
    logic big_endian;
    logic sync_green;
    logic pedestal;
  } pdt_ctrl_t;
endpackage : pdt_pkg

// ### core/pdt_test_ctrl.sv
/*
 Test register and upper general control bits of a palette converter.
 Assumes the palette word for the current pixel arrives on the pixel clock
 domain (i_ref_clk), with vsync, blank and comparator from pins.
*/
// Strobed register access and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`include "pdt_params.svh"
module pdt_test_ctrl #(
  parameter logic [7:0] ID_VALUE = 8'h5A // Arbitrary identification value
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire logic i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire pdt_pkg::pdt_rgb_t i_palette,
  input wire logic i_pixel_valid,
  input wire logic i_vsync_b,
  input wire logic i_blank_b,
  input wire logic i_cmp,
  output pdt_pkg::pdt_ctrl_t o_ctrl,
  output logic [3:0] o_cmp_sel
);
  import pdt_pkg::*;

  logic [7:0] gen_q;
  logic [2:0] chan_q;
  logic [3:0] sel_q;
  logic result_q;
  logic [7:0] acc_q;
  logic [7:0] ones_q;
  logic phase_q;
  logic [1:0] vs_sync_q;
  logic vs_prev_q;
  logic [1:0] bl_sync_q;
  logic bl_prev_q;
  logic [1:0] cmp_sync_q;
  logic vs_fall;
  logic bl_fall;
  logic [7:0] data_sel;
  logic [3:0] pop;
  logic [8:0] sum;

  function automatic logic [3:0] count_ones(input logic [7:0] b);
    logic [3:0] n;
    n = 4'h0;
    for (int k = 0; k < 8; k++) begin
      n = n + {3'h0, b[k]};
    end
    return n;
  endfunction : count_ones

  // Palette byte for a colour code; ones codes share the low two bits
  function automatic logic [7:0] pick(input logic [1:0] c,
                                      input pdt_rgb_t p);
    case (c)
      2'h0: pick = p.red;
      2'h1: pick = p.green;
      default: pick = p.blue;
    endcase
  endfunction : pick

  // Pins are asynchronous to the pixel clock
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      vs_sync_q <= 2'h3;
      vs_prev_q <= 1'b1;
      bl_sync_q <= 2'h3;
      bl_prev_q <= 1'b1;
      cmp_sync_q <= 2'h0;
    end else begin
      vs_sync_q <= {vs_sync_q[0], i_vsync_b};
      vs_prev_q <= vs_sync_q[1];
      bl_sync_q <= {bl_sync_q[0], i_blank_b};
      bl_prev_q <= bl_sync_q[1];
      cmp_sync_q <= {cmp_sync_q[0], i_cmp};
    end
  end

  assign vs_fall = vs_prev_q && !vs_sync_q[1];
  assign bl_fall = bl_prev_q && !bl_sync_q[1];

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      gen_q <= `PDT_GEN_RESET;
    end else if (i_wr && i_addr == `PDT_ADDR_GENERAL) begin
      gen_q <= i_wdata;
    end
  end

  assign o_ctrl.pedestal = gen_q[`PDT_BIT_PEDESTAL];
  assign o_ctrl.sync_green = gen_q[`PDT_BIT_SYNC_GREEN];
  assign o_ctrl.big_endian = gen_q[`PDT_BIT_BIG_ENDIAN];
  // Drives the pin only; nothing inside reads it
  assign o_ctrl.ext_sel = gen_q[`PDT_BIT_EXT_SEL];

  // Channel selector: host write wins, then read advance, then frame advance
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      chan_q <= `PDT_CH_RED;
      sel_q <= 4'h0;
    end else if (i_wr && i_addr == `PDT_ADDR_TEST) begin
      chan_q <= i_wdata[2:0];
      sel_q <= i_wdata[7:4];
    end else if (i_rd && i_addr == `PDT_ADDR_TEST) begin
      case (chan_q)
        `PDT_CH_RED: chan_q <= `PDT_CH_GREEN;
        `PDT_CH_GREEN: chan_q <= `PDT_CH_BLUE;
        `PDT_CH_BLUE: chan_q <= `PDT_CH_RED;
        `PDT_CH_IDENT: chan_q <= `PDT_CH_RED;
        default: chan_q <= chan_q;
      endcase
    end else if (vs_fall) begin
      case (chan_q)
        `PDT_CH_ONES_RED: chan_q <= `PDT_CH_ONES_GREEN;
        `PDT_CH_ONES_GREEN: chan_q <= `PDT_CH_ONES_BLUE;
        `PDT_CH_ONES_BLUE: chan_q <= `PDT_CH_ONES_RED;
        default: chan_q <= chan_q;
      endcase
    end
  end

  assign o_cmp_sel = sel_q;

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      result_q <= 1'b0;
    end else if (bl_fall) begin
      result_q <= cmp_sync_q[1];
    end
  end

  // Phase only toggles, never reloads, so it carries over from frame to frame
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      phase_q <= 1'b0;
    end else if (i_pixel_valid) begin
      phase_q <= !phase_q;
    end
  end

  assign pop = count_ones(pick(chan_q[1:0], i_palette));
  assign sum = {1'b0, acc_q} + {5'h00, pop};

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      acc_q <= 8'h00;
      ones_q <= 8'h00;
    end else if (vs_fall) begin
      ones_q <= acc_q;
      acc_q <= 8'h00;
    end else if (chan_q[2] && chan_q != `PDT_CH_ANALOG && i_pixel_valid
                 && phase_q) begin
      acc_q <= sum[8] ? `PDT_ACC_MAX : sum[7:0];
    end
  end

  always_comb begin
    case (chan_q)
      `PDT_CH_RED: data_sel = i_palette.red;
      `PDT_CH_GREEN: data_sel = i_palette.green;
      `PDT_CH_BLUE: data_sel = i_palette.blue;
      `PDT_CH_IDENT: data_sel = ID_VALUE;
      `PDT_CH_ANALOG: data_sel = {sel_q, result_q, 3'h7};
      default: data_sel = ones_q;
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      o_rdata <= (i_addr == `PDT_ADDR_TEST) ? data_sel : gen_q;
    end else begin
      o_rdata <= 8'h00;
    end
  end
endmodule : pdt_test_ctrl

// ### dv/pdt_test_ctrl_sva.sv
/* Port checker for the palette test and control block.
 Assumes it is bound to pdt_test_ctrl and sees only its ports. */
`timescale 1ns/10ps
module pdt_test_ctrl_sva #(
  parameter logic [7:0] ID_VALUE = 8'h5A
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire logic i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  input wire pdt_pkg::pdt_rgb_t i_palette,
  input wire pdt_pkg::pdt_ctrl_t o_ctrl,
  input wire logic [3:0] o_cmp_sel
);
  import pdt_pkg::*;
  wire wg = i_wr && !i_addr;
  wire wt = i_wr && i_addr;
  wire rt = i_rd && i_addr;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);
  AST_RD_IDLE: assert property (!i_rd |=> o_rdata == 8'h00)
    else $error("read data not idle");
  AST_CTRL_WR: assert property (
    wg |=> o_ctrl == $past(i_wdata[7:4])) else $error("control not stored");
  AST_CTRL_HOLD: assert property (!wg |=> $stable(o_ctrl))
    else $error("control changed without write");
  AST_SEL_WR: assert property (
    wt |=> o_cmp_sel == $past(i_wdata[7:4])) else $error("selects not stored");
  AST_SEL_HOLD: assert property (!wt |=> $stable(o_cmp_sel))
    else $error("selects changed without write");
  AST_GEN_READ: assert property (
    i_rd && !i_addr |=> o_rdata[7:4] == $past(o_ctrl))
    else $error("control readback wrong");
  AST_ID_READ: assert property (
    wt && i_wdata[2:0] == 3'h3 ##2 rt |=> o_rdata == ID_VALUE)
    else $error("identification read wrong");
  AST_PAL_READ: assert property (
    wt && i_wdata[2:0] == 3'h0 ##2 rt |=> o_rdata == $past(i_palette.red))
    else $error("palette red read wrong");
  AST_ANA_READ: assert property (
    rt && o_cmp_sel != 4'h0 |=> o_rdata[7:4] == $past(o_cmp_sel) &&
    o_rdata[2:0] == 3'h7) else $error("analog read wrong");
  cover property (rt ##1 o_rdata == ID_VALUE);
  cover property (rt && o_cmp_sel == 4'hA);
  cover property (wg && i_wdata[7]);
endmodule : pdt_test_ctrl_sva
bind pdt_test_ctrl pdt_test_ctrl_sva #(.ID_VALUE(ID_VALUE)) i_sva (
  .i_ref_clk, .i_rst_b, .i_addr, .i_wdata, .i_wr, .i_rd,
  .o_rdata, .i_palette, .o_ctrl, .o_cmp_sel);

// ### dv/pdt_pixel_src.sv
/* Pixel source model: 80 valid pixels, then 20 blanked cycles with a
 vsync pulse. Assumes the bench clock and reset. */
`timescale 1ns/10ps
module pdt_pixel_src (
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  output pdt_pkg::pdt_rgb_t o_palette,
  output logic o_pixel_valid,
  output logic o_vsync_b,
  output logic o_blank_b
);
  import pdt_pkg::*;
  logic [6:0] cnt_q;
  // Word held constant so readback and ones counts stay steady
  assign o_palette = '{red: 8'h12, green: 8'h34, blue: 8'hFF};
  assign o_pixel_valid = cnt_q < 7'h50;
  assign o_blank_b = o_pixel_valid;
  assign o_vsync_b = !(cnt_q >= 7'h54 && cnt_q < 7'h59);
  // Even valid-pixel count per frame (80) keeps the half-rate sample count fixed
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_q <= 7'h00;
    end else begin
      cnt_q <= (cnt_q == 7'h63) ? 7'h00 : cnt_q + 7'h01;
    end
  end
endmodule : pdt_pixel_src

// ### dv/pdt_test_ctrl_test.sv
/* Self-checking bench for pdt_test_ctrl with a pixel source model.
 Assumes design, package, model and checker are compiled first. */
`timescale 1ns/10ps
module pdt_test_ctrl_test;
  import pdt_pkg::*;
  localparam logic [7:0] ID = 8'hA5; // Arbitrary identification value
  logic clk = 1'b0, rst_b = 1'b0, addr = 1'b0, wr = 1'b0, rd = 1'b0;
  logic cmp = 1'b0, pv, vs_b, bl_b;
  logic [7:0] wdata = 8'h00, rdata;
  logic [7:0] seq [6] = '{ID, 8'h12, 8'h34, 8'hFF, 8'h12, 8'h34};
  logic [7:0] ones [3] = '{8'h78, 8'hFF, 8'h50};
  logic [3:0] codes [4] = '{4'hA, 4'h9, 4'h6, 4'h5};
  logic [3:0] sel;
  pdt_rgb_t pal;
  pdt_ctrl_t ctrl;
  int fail_count = 0, checks_done = 0;
  always #12.5 clk = !clk;
  pdt_pixel_src i_src (.i_ref_clk(clk), .i_rst_b(rst_b), .o_palette(pal),
    .o_pixel_valid(pv), .o_vsync_b(vs_b), .o_blank_b(bl_b));
  pdt_test_ctrl #(.ID_VALUE(ID)) i_dut (.i_ref_clk(clk), .i_rst_b(rst_b),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .i_palette(pal), .i_pixel_valid(pv), .i_vsync_b(vs_b), .i_blank_b(bl_b),
    .i_cmp(cmp), .o_ctrl(ctrl), .o_cmp_sel(sel));
  task complete_run;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : complete_run
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task wr_reg(input logic a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    // Let the stored value settle before a caller compares outputs
    #1;
  endtask : wr_reg
  task rd_reg(input logic a, input logic [7:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask : rd_reg
  // Waits for a falling edge of vsync or blank, then for the synchroniser
  task wfall(input bit b);
    int n;
    n = 0;
    while (n < 400 && (b ? bl_b : vs_b) !== 1'b1) begin
      @(posedge clk);
      n++;
    end
    while (n < 400 && (b ? bl_b : vs_b) !== 1'b0) begin
      @(posedge clk);
      n++;
    end
    if (n >= 400) begin
      fail_count++;
      complete_run;
    end
    repeat (6) @(posedge clk);
  endtask : wfall
  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    rd_reg(1'b0, 8'h03);
    rd_reg(1'b1, 8'h12);
    wr_reg(1'b0, 8'hF3);
    chk({4'h0, ctrl}, 8'h0F);
    rd_reg(1'b0, 8'hF3);
    wr_reg(1'b0, 8'h50);
    chk({4'h0, ctrl}, 8'h05);
    wr_reg(1'b1, 8'h00);
    for (int i = 1; i < 5; i++) rd_reg(1'b1, seq[i]);
    wr_reg(1'b1, 8'h03);
    for (int i = 0; i < 6; i++) rd_reg(1'b1, seq[i]);
    wr_reg(1'b1, 8'h04);
    wfall(1'b0);
    for (int i = 0; i < 3; i++) begin
      wfall(1'b0);
      rd_reg(1'b1, ones[i]);
    end
    for (int k = 0; k < 4; k++) begin
      wr_reg(1'b1, {codes[k], 4'hF});
      cmp <= k[0];
      wfall(1'b1);
      rd_reg(1'b1, {codes[k], k[0], 3'h7});
    end
    wr_reg(1'b1, 8'h00);
    complete_run;
  end
endmodule : pdt_test_ctrl_test
